// ---- hdl/cpurf_core.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cpurf_regs.svh"

// Operation
// - Eight-bit working byte holds ALU results
// - Index pair from two bytes addresses operands
// - Reset loads stack pointer with 00FF
// - Low reload sets pointer low byte FF
// - Push decrements, pull increments stack pointer
// - Stack offset modes add offset to pointer
// - Fetch advances pointer; jumps load new target
// - Reset loads fetch pointer from FFFE/FFFF
// - Flag bits six and five read one
// - Overflow flag tracks signed overflow
// - Nibble carry from bit three addition
// - Mask set ignores maskable requests
// - Entry stacks registers, masks, then vectors
// - Entry never stacks upper index byte
// - Highest priority pending request served first
// - Return restores registers and saved mask
// - Reset sets mask; unmask or return clears
// - Sign flag copies result bit seven
// - Zero flag set for zero result
// - Carry from add, borrow, shifts
module cpurf_core (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire cpurf_pkg::cpurf_req_s seq_req,
    input wire logic [7:0] irq_pend,
    input wire logic [7:0] mem_rdata,
    output cpurf_pkg::cpurf_mem_s mem_req,
    output logic busy,
    output logic [7:0] irq_ack,
    output logic signed_lt,
    output logic [15:0] eff_addr,
    output logic [7:0] work_byte,
    output logic [15:0] index_pair,
    output logic [15:0] stack_top_ptr,
    output logic [15:0] next_fetch_ptr,
    output logic [7:0] flag_reg
);
    // Byte-lane merge for bus writes
    function automatic logic [15:0] cpurf_merge(
        input logic [15:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb);
        logic [15:0] res;
        res = old_v;
        if (strb[0]) res[7:0] = new_v[7:0];
        if (strb[1]) res[15:8] = new_v[15:8];
        return res;
    endfunction : cpurf_merge

    // Mapped register check
    function automatic logic cpurf_hit(input logic [7:0] ad);
        logic [7:0] al;
        al = {ad[7:2], 2'b00};
        return (al == `CPURF_OFS_WORK) || (al == `CPURF_OFS_INDEX)
            || (al == `CPURF_OFS_STACK) || (al == `CPURF_OFS_FETCH)
            || (al == `CPURF_OFS_FLAG) || (al == `CPURF_OFS_STAT);
    endfunction : cpurf_hit

    // Lowest set bit wins
    function automatic logic [2:0] cpurf_prio(input logic [7:0] p);
        logic [2:0] n;
        n = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (p[i]) n = 3'(i);
        end
        return n;
    endfunction : cpurf_prio

    // ALU result and new flags
    function automatic logic [15:0] cpurf_alu(
        input cpurf_pkg::cpurf_op_e sel,
        input logic [7:0] a,
        input logic [7:0] m,
        input logic [7:0] f);
        logic [8:0] s;
        logic [4:0] hs;
        logic [7:0] nf;
        logic [7:0] cor;
        logic cin;
        logic lo;
        logic hc;
        nf = f;
        hs = 5'h00;
        cin = f[`CPURF_FLG_C] & ((sel == cpurf_pkg::OP_ADC)
            | (sel == cpurf_pkg::OP_SBC));
        lo = f[`CPURF_FLG_H] | (a[3:0] > 4'h9);
        hc = f[`CPURF_FLG_C] | (a > 8'h99);
        cor = {1'b0, hc, hc, 1'b0, 1'b0, lo, lo, 1'b0};
        unique case (sel)
            cpurf_pkg::OP_ADD, cpurf_pkg::OP_ADC: begin
                s = {1'b0, a} + {1'b0, m} + {8'h00, cin};
                hs = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
                nf[`CPURF_FLG_H] = hs[4];
                nf[`CPURF_FLG_C] = s[8];
                nf[`CPURF_FLG_V] = (a[7] == m[7]) && (s[7] != a[7]);
            end
            cpurf_pkg::OP_SUB, cpurf_pkg::OP_SBC: begin
                s = {1'b0, a} - {1'b0, m} - {8'h00, cin};
                nf[`CPURF_FLG_C] = s[8];
                nf[`CPURF_FLG_V] = (a[7] != m[7]) && (s[7] != a[7]);
            end
            cpurf_pkg::OP_AND, cpurf_pkg::OP_ORA,
            cpurf_pkg::OP_EOR, cpurf_pkg::OP_LDA: begin
                s = (sel == cpurf_pkg::OP_AND) ? {1'b0, a & m}
                    : (sel == cpurf_pkg::OP_ORA) ? {1'b0, a | m}
                    : (sel == cpurf_pkg::OP_EOR) ? {1'b0, a ^ m}
                    : {1'b0, m};
                nf[`CPURF_FLG_V] = 1'b0;
            end
            cpurf_pkg::OP_ASL: begin
                s = {1'b0, a[6:0], 1'b0};
                nf[`CPURF_FLG_C] = a[7];
                nf[`CPURF_FLG_V] = a[7] ^ a[6];
            end
            cpurf_pkg::OP_LSR: begin
                s = {2'b00, a[7:1]};
                nf[`CPURF_FLG_C] = a[0];
                nf[`CPURF_FLG_V] = a[0];
            end
            cpurf_pkg::OP_DAA: begin
                s = {1'b0, a} + {1'b0, cor};
                nf[`CPURF_FLG_C] = hc;
            end
            default: s = {1'b0, a};
        endcase
        nf[`CPURF_FLG_N] = s[7];
        nf[`CPURF_FLG_Z] = (s[7:0] == 8'h00);
        return {nf | `CPURF_FLAG_ONES, s[7:0]};
    endfunction : cpurf_alu

    logic [7:0] a_q, a_d, h_q, h_d, x_q, x_d, ccr_q, ccr_d;
    logic [15:0] sp_q, sp_d, pc_q, pc_d, vec_q, vec_d, ea_q, ea_d;
    logic [2:0] idx_q, idx_d;
    cpurf_pkg::cpurf_state_e st_q, st_d;
    cpurf_pkg::cpurf_mem_s mem_q, mem_d;
    logic [7:0] ack_q, ack_d;
    logic busy_q, slt_q;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0] aw_q, aw_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

    // Request decode
    wire wr_do = aw_have_q & w_have_q & ~bvalid_q;
    wire rd_do = s_axi_arvalid & arready_q;
    wire idle = (st_q == cpurf_pkg::ST_IDLE);
    wire op_go = seq_req.valid & idle;
    wire irq_go = idle & ~seq_req.valid & ~ccr_q[`CPURF_FLG_I]
        & (|irq_pend);
    wire [2:0] irq_sel = cpurf_prio(irq_pend);
    wire [15:0] alu_out = cpurf_alu(seq_req.op, a_q,
        seq_req.arg[7:0], ccr_q);
    wire alu_op = (seq_req.op >= cpurf_pkg::OP_ADD)
        && (seq_req.op <= cpurf_pkg::OP_DAA);
    wire last_pull = (idx_q == `CPURF_STACK_LAST)
        || (idx_q == `CPURF_PULL_H);
    // Frame order PCL, PCH, X, A, flags; upper index left out
    wire [7:0] push_byte = (idx_q == 3'h0) ? pc_q[7:0]
        : (idx_q == 3'h1) ? pc_q[15:8]
        : (idx_q == 3'h2) ? x_q
        : (idx_q == 3'h3) ? a_q : ccr_q;
    wire [7:0] ar_al = {s_axi_araddr[7:2], 2'b00};
    wire [31:0] rd_mux = (ar_al == `CPURF_OFS_WORK) ? {24'h0, a_q}
        : (ar_al == `CPURF_OFS_INDEX) ? {16'h0, h_q, x_q}
        : (ar_al == `CPURF_OFS_STACK) ? {16'h0, sp_q}
        : (ar_al == `CPURF_OFS_FETCH) ? {16'h0, pc_q}
        : (ar_al == `CPURF_OFS_FLAG) ? {24'h0, ccr_q}
        : (ar_al == `CPURF_OFS_STAT) ? {28'h0, st_q, busy_q}
        : 32'h0;

    // Bus slave handshakes
    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        aw_d = aw_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_awvalid & awready_q) begin
            aw_have_d = 1'b1;
            aw_d = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid & wready_q) begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (bvalid_q & s_axi_bready) bvalid_d = 1'b0;
        if (wr_do) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = cpurf_hit(aw_q) ? `CPURF_RESP_OK : `CPURF_RESP_ERR;
        end
        if (rvalid_q & s_axi_rready) rvalid_d = 1'b0;
        if (rd_do) begin
            rvalid_d = 1'b1;
            rdata_d = rd_mux;
            rresp_d = cpurf_hit(s_axi_araddr) ? `CPURF_RESP_OK
                : `CPURF_RESP_ERR;
        end
        awready_d = ~aw_have_d & ~bvalid_d;
        wready_d = ~w_have_d & ~bvalid_d;
        arready_d = ~rvalid_d;
    end

    // Register updates: bus writes first, sequencer wins
    always_comb begin
        a_d = a_q;
        h_d = h_q;
        x_d = x_q;
        sp_d = sp_q;
        pc_d = pc_q;
        ccr_d = ccr_q;
        st_d = st_q;
        idx_d = idx_q;
        vec_d = vec_q;
        ea_d = ea_q;
        mem_d = '0;
        ack_d = 8'h00;
        if (wr_do) begin
            unique case (aw_q)
                `CPURF_OFS_WORK: if (wstrb_q[0]) a_d = wdata_q[7:0];
                `CPURF_OFS_INDEX:
                    {h_d, x_d} = cpurf_merge({h_q, x_q}, wdata_q, wstrb_q);
                `CPURF_OFS_STACK: sp_d = cpurf_merge(sp_q, wdata_q, wstrb_q);
                `CPURF_OFS_FETCH: pc_d = cpurf_merge(pc_q, wdata_q, wstrb_q);
                `CPURF_OFS_FLAG: if (wstrb_q[0]) ccr_d = wdata_q[7:0]
                    | `CPURF_FLAG_ONES | (ccr_q & `CPURF_FLAG_IMASK);
                default: ;
            endcase
        end
        unique case (st_q)
            cpurf_pkg::ST_IDLE: begin
                if (op_go && alu_op) begin
                    a_d = alu_out[7:0];
                    ccr_d = alu_out[15:8];
                end else if (op_go) begin
                    unique case (seq_req.op)
                        cpurf_pkg::OP_FETCH: pc_d = pc_q + 16'h0001;
                        cpurf_pkg::OP_JUMP: pc_d = seq_req.arg;
                        cpurf_pkg::OP_RSP: sp_d[7:0] = `CPURF_SP_LOW;
                        cpurf_pkg::OP_PUSH_UPPER_INDEX: begin
                            mem_d.wr = 1'b1;
                            mem_d.addr = sp_q;
                            mem_d.wdata = h_q;
                            sp_d = sp_q - 16'h0001;
                        end
                        cpurf_pkg::OP_PULL_UPPER_INDEX: begin
                            idx_d = `CPURF_PULL_H;
                            st_d = cpurf_pkg::ST_PULL;
                        end
                        cpurf_pkg::OP_CLI: ccr_d[`CPURF_FLG_I] = 1'b0;
                        cpurf_pkg::OP_SEI: ccr_d[`CPURF_FLG_I] = 1'b1;
                        cpurf_pkg::OP_RTI: begin
                            idx_d = 3'h0;
                            st_d = cpurf_pkg::ST_PULL;
                        end
                        cpurf_pkg::OP_SPA8:
                            ea_d = sp_q + {8'h00, seq_req.arg[7:0]};
                        cpurf_pkg::OP_SPA16: ea_d = sp_q + seq_req.arg;
                        cpurf_pkg::OP_IXADR: ea_d = {h_q, x_q} + seq_req.arg;
                        cpurf_pkg::OP_LDHX: {h_d, x_d} = seq_req.arg;
                        default: ;
                    endcase
                end else if (irq_go) begin
                    idx_d = 3'h0;
                    st_d = cpurf_pkg::ST_PUSH;
                    vec_d = `CPURF_IRQ_VEC - {12'h000, irq_sel, 1'b0};
                    ack_d = 8'h01 << irq_sel;
                end
            end
            cpurf_pkg::ST_PUSH: begin
                mem_d.wr = 1'b1;
                mem_d.addr = sp_q;
                mem_d.wdata = push_byte;
                sp_d = sp_q - 16'h0001;
                idx_d = idx_q + 3'h1;
                if (idx_q == `CPURF_STACK_LAST) st_d = cpurf_pkg::ST_MASK;
            end
            cpurf_pkg::ST_MASK: begin
                ccr_d[`CPURF_FLG_I] = 1'b1;
                st_d = cpurf_pkg::ST_VRDH;
            end
            cpurf_pkg::ST_VRDH: begin
                mem_d.rd = 1'b1;
                mem_d.addr = vec_q;
                st_d = cpurf_pkg::ST_VDH;
            end
            cpurf_pkg::ST_VDH: begin
                pc_d[15:8] = mem_rdata;
                mem_d.rd = 1'b1;
                mem_d.addr = vec_q + 16'h0001;
                st_d = cpurf_pkg::ST_VDL;
            end
            cpurf_pkg::ST_VDL: begin
                pc_d[7:0] = mem_rdata;
                st_d = cpurf_pkg::ST_IDLE;
            end
            cpurf_pkg::ST_PULL: begin
                sp_d = sp_q + 16'h0001;
                mem_d.rd = 1'b1;
                mem_d.addr = sp_q + 16'h0001;
                st_d = cpurf_pkg::ST_PDAT;
            end
            cpurf_pkg::ST_PDAT: begin
                unique case (idx_q)
                    3'h0: ccr_d = mem_rdata | `CPURF_FLAG_ONES;
                    3'h1: a_d = mem_rdata;
                    3'h2: x_d = mem_rdata;
                    3'h3: pc_d[15:8] = mem_rdata;
                    3'h4: pc_d[7:0] = mem_rdata;
                    default: h_d = mem_rdata;
                endcase
                idx_d = idx_q + 3'h1;
                st_d = last_pull ? cpurf_pkg::ST_IDLE : cpurf_pkg::ST_PULL;
            end
        endcase
    end

    // State registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_q <= 8'h00;
            h_q <= 8'h00;
            x_q <= 8'h00;
            sp_q <= `CPURF_SP_RST;
            pc_q <= 16'h0000;
            ccr_q <= `CPURF_FLAG_RST;
            st_q <= cpurf_pkg::ST_VRDH;
            idx_q <= 3'h0;
            vec_q <= `CPURF_RST_VEC;
            ea_q <= 16'h0000;
            mem_q <= '0;
            ack_q <= 8'h00;
            busy_q <= 1'b1;
            slt_q <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= 2'h0;
        end else begin
            a_q <= a_d;
            h_q <= h_d;
            x_q <= x_d;
            sp_q <= sp_d;
            pc_q <= pc_d;
            ccr_q <= ccr_d | `CPURF_FLAG_ONES;
            st_q <= st_d;
            idx_q <= idx_d;
            vec_q <= vec_d;
            ea_q <= ea_d;
            mem_q <= mem_d;
            ack_q <= ack_d;
            busy_q <= (st_d != cpurf_pkg::ST_IDLE);
            slt_q <= ccr_d[`CPURF_FLG_N] ^ ccr_d[`CPURF_FLG_V];
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            aw_q <= aw_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // Outputs straight from flops
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign mem_req = mem_q;
    assign busy = busy_q;
    assign irq_ack = ack_q;
    assign signed_lt = slt_q;
    assign eff_addr = ea_q;
    assign work_byte = a_q;
    assign index_pair = {h_q, x_q};
    assign stack_top_ptr = sp_q;
    assign next_fetch_ptr = pc_q;
    assign flag_reg = ccr_q;

    // Checks on stack, fetch, flags and entry
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire op_rsp = op_go && (seq_req.op == cpurf_pkg::OP_RSP) && !wr_do;
    wire op_fet = op_go && (seq_req.op == cpurf_pkg::OP_FETCH) && !wr_do;

    a_sp_reset: assert property ($rose(aresetn) |->
        sp_q == `CPURF_SP_RST) else $error("stack reset value");
    a_rsp_low: assert property (op_rsp |=>
        sp_q == {$past(sp_q[15:8]), `CPURF_SP_LOW})
        else $error("low reload wrong");
    a_push_dec: assert property (st_q == cpurf_pkg::ST_PUSH |=>
        sp_q == $past(sp_q) - 16'h0001) else $error("push no decrement");
    a_fetch_inc: assert property (op_fet |=>
        pc_q == $past(pc_q) + 16'h0001) else $error("fetch no advance");
    a_reset_vec: assert property ($rose(aresetn) |-> ##1
        (mem_q.rd && mem_q.addr == `CPURF_RST_VEC))
        else $error("reset vector not read");
    a_flag_ones: assert property (ccr_q[6:5] == 2'b11)
        else $error("fixed flag bits low");
    a_irq_masked: assert property ((ack_q != 8'h00) |->
        !$past(ccr_q[`CPURF_FLG_I]))
        else $error("request taken while masked");
    a_entry_seq: assert property (irq_go |=>
        st_q == cpurf_pkg::ST_PUSH [*5] ##1 st_q == cpurf_pkg::ST_MASK
        ##1 (ccr_q[`CPURF_FLG_I] && st_q == cpurf_pkg::ST_VRDH))
        else $error("entry order wrong");
    a_irq_prio: assert property (irq_go |=>
        ack_q == ($past(irq_pend) & (~$past(irq_pend) + 8'h01)))
        else $error("wrong request served");
    a_rti_mask: assert property ((st_q == cpurf_pkg::ST_PDAT
        && idx_q == 3'h0) |=> ccr_q[`CPURF_FLG_I]
        == $past(mem_rdata[`CPURF_FLG_I])) else $error("mask not restored");
    a_zero_flag: assert property ((op_go && alu_op) |=>
        ccr_q[`CPURF_FLG_Z] == (a_q == 8'h00)) else $error("zero flag");

    c_irq_entry: cover property (irq_go ##7 st_q == cpurf_pkg::ST_VRDH);
    c_return: cover property (op_go && seq_req.op == cpurf_pkg::OP_RTI);
    c_bus_write: cover property (wr_do && aw_q == `CPURF_OFS_FLAG);
endmodule : cpurf_core
`default_nettype wire

// ---- hdl/cpurf_regs.svh ----
`ifndef CPURF_REGS_SVH
`define CPURF_REGS_SVH
// Bus register byte offsets
`define CPURF_OFS_WORK 8'h00
`define CPURF_OFS_INDEX 8'h04
`define CPURF_OFS_STACK 8'h08
`define CPURF_OFS_FETCH 8'h0c
`define CPURF_OFS_FLAG 8'h10
`define CPURF_OFS_STAT 8'h14
// Reset values and fixed patterns
`define CPURF_SP_RST 16'h00ff
`define CPURF_SP_LOW 8'hff
`define CPURF_FLAG_RST 8'h68
`define CPURF_FLAG_ONES 8'h60
`define CPURF_FLAG_IMASK 8'h08
`define CPURF_RST_VEC 16'hfffe
`define CPURF_IRQ_VEC 16'hfffc
// Flag bit positions
`define CPURF_FLG_V 7
`define CPURF_FLG_H 4
`define CPURF_FLG_I 3
`define CPURF_FLG_N 2
`define CPURF_FLG_Z 1
`define CPURF_FLG_C 0
// Stack frame walk
`define CPURF_STACK_LAST 3'h4
`define CPURF_PULL_H 3'h5
// Bus responses
`define CPURF_RESP_OK 2'h0
`define CPURF_RESP_ERR 2'h2
`endif

// ---- hdl/cpurf_pkg.sv ----
package cpurf_pkg;
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_ADD = 5'h01, OP_ADC = 5'h02,
        OP_SUB = 5'h03, OP_SBC = 5'h04, OP_AND = 5'h05,
        OP_ORA = 5'h06, OP_EOR = 5'h07, OP_LDA = 5'h08,
        OP_ASL = 5'h09, OP_LSR = 5'h0a, OP_DAA = 5'h0b,
        OP_FETCH = 5'h0c, OP_JUMP = 5'h0d, OP_RSP = 5'h0e,
        OP_PUSH_UPPER_INDEX = 5'h0f, OP_PULL_UPPER_INDEX = 5'h10, OP_CLI = 5'h11,
        OP_SEI = 5'h12, OP_RTI = 5'h13, OP_SPA8 = 5'h14,
        OP_SPA16 = 5'h15, OP_IXADR = 5'h16, OP_LDHX = 5'h17
    } cpurf_op_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_PUSH = 3'h1, ST_MASK = 3'h2,
        ST_VRDH = 3'h3, ST_VDH = 3'h4, ST_VDL = 3'h5,
        ST_PULL = 3'h6, ST_PDAT = 3'h7
    } cpurf_state_e;

    typedef struct packed {
        logic valid;
        cpurf_op_e op;
        logic [15:0] arg;
    } cpurf_req_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cpurf_mem_s;
endpackage : cpurf_pkg

// ---- dv/cpurf_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpurf_mem_model (
    input wire logic aclk,
    input wire cpurf_pkg::cpurf_mem_s mem_req,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;
    // Every byte starts as its low address, vectors included
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = i[7:0];
    end
    // Byte shown while the read strobe stands, last byte read inverted otherwise
    assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~last_q;
    // Write port and last byte read
    always @(posedge aclk) begin
        if (mem_req.wr) mem[mem_req.addr] <= mem_req.wdata;
        if (mem_req.rd) last_q <= mem[mem_req.addr];
    end
endmodule : cpurf_mem_model
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cpurf_regs.svh"
module testbench;
    logic aclk = 1'b0;
    logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, busy, signed_lt;
    logic [7:0] s_axi_awaddr, s_axi_araddr, irq_pend, mem_rdata, irq_ack;
    logic [7:0] work_byte, flag_reg, ack_seen;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] eff_addr, index_pair, stack_top_ptr, next_fetch_ptr;
    cpurf_pkg::cpurf_req_s seq_req;
    cpurf_pkg::cpurf_mem_s mem_req;
    int err_total = 0;
    int n_checks = 0;
    cpurf_core dut_u (.*);
    cpurf_mem_model mem_u (.aclk(aclk), .mem_req(mem_req),
        .mem_rdata(mem_rdata));
    always #2 aclk = ~aclk;
    // Remember the last accepted request
    always @(posedge aclk) begin
        if (!aresetn) ack_seen <= 8'h00;
        else if (irq_ack != 8'h00) ack_seen <= irq_ack;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
            s_axi_awvalid <= !ad;
            s_axi_wvalid <= !wd;
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] ed);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, `CPURF_RESP_OK);
    endtask : axr
    task automatic idle;
        @(posedge aclk);
        while (busy !== 1'b0) @(posedge aclk);
    endtask : idle
    task automatic op(input cpurf_pkg::cpurf_op_e o, input logic [15:0] g);
        while (busy !== 1'b0) @(posedge aclk);
        seq_req <= '{1'b1, o, g};
        @(posedge aclk);
        seq_req.valid <= 1'b0;
        @(posedge aclk);
    endtask : op
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge aclk);
        err_total++;
        conclude();
    end
    task automatic t_reset;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        idle();
        chk(stack_top_ptr, `CPURF_SP_RST);
        chk(next_fetch_ptr, 16'hfeff);
        chk(flag_reg, 8'h68);
        $display("test reset done");
    endtask : t_reset
    task automatic t_bus;
        axw(`CPURF_OFS_FLAG, 32'h0, `CPURF_RESP_OK);
        axr(`CPURF_OFS_FLAG, 32'h68);
        axw(8'h18, 32'h5, `CPURF_RESP_ERR);
        axw(`CPURF_OFS_INDEX, 32'h5a3c, `CPURF_RESP_OK);
        axr(`CPURF_OFS_INDEX, 32'h5a3c);
        $display("test bus done");
    endtask : t_bus
    task automatic t_alu;
        op(cpurf_pkg::OP_LDA, 16'h007f);
        op(cpurf_pkg::OP_ADD, 16'h0001);
        chk(work_byte, 8'h80);
        chk(flag_reg, 8'hfc);
        chk(signed_lt, 1'b0);
        $display("test alu done");
    endtask : t_alu
    task automatic t_stack;
        axw(`CPURF_OFS_STACK, 32'h1234, `CPURF_RESP_OK);
        op(cpurf_pkg::OP_RSP, 16'h0);
        chk(stack_top_ptr, 16'h12ff);
        op(cpurf_pkg::OP_SPA8, 16'h0010);
        chk(eff_addr, 16'h130f);
        $display("test stack done");
    endtask : t_stack
    task automatic t_irq;
        axw(`CPURF_OFS_STACK, 32'h0080, `CPURF_RESP_OK);
        irq_pend <= 8'h06;
        repeat (4) @(posedge aclk);
        chk(ack_seen, 8'h00);
        op(cpurf_pkg::OP_CLI, 16'h0);
        idle();
        irq_pend <= 8'h00;
        chk(ack_seen, 8'h02);
        chk(stack_top_ptr, 16'h007b);
        chk(flag_reg, 8'hfc);
        chk(next_fetch_ptr, 16'hfafb);
        chk({mem_u.mem[16'h80], mem_u.mem[16'h7f]}, 16'hfffe);
        chk({mem_u.mem[16'h7e], mem_u.mem[16'h7d]}, 16'h3c80);
        chk(mem_u.mem[16'h7c], 8'hf4);
        chk(mem_u.mem[16'h7b], 8'h7b);
        $display("test interrupt done");
    endtask : t_irq
    task automatic t_ret;
        op(cpurf_pkg::OP_RTI, 16'h0);
        chk(busy, 1'b1);
        idle();
        chk(stack_top_ptr, 16'h0080);
        chk(flag_reg, 8'hf4);
        chk(next_fetch_ptr, 16'hfeff);
        $display("test return done");
    endtask : t_ret
    task automatic t_ops;
        op(cpurf_pkg::OP_FETCH, 16'h0);
        chk(next_fetch_ptr, 16'hff00);
        op(cpurf_pkg::OP_JUMP, 16'h4321);
        chk(next_fetch_ptr, 16'h4321);
        op(cpurf_pkg::OP_SPA16, 16'h0100);
        chk(eff_addr, 16'h0180);
        op(cpurf_pkg::OP_LDHX, 16'h1000);
        op(cpurf_pkg::OP_IXADR, 16'h0024);
        chk(eff_addr, 16'h1024);
        op(cpurf_pkg::OP_PUSH_UPPER_INDEX, 16'h0);
        chk(stack_top_ptr, 16'h007f);
        op(cpurf_pkg::OP_LDHX, 16'h0000);
        chk(mem_u.mem[16'h80], 8'h10);
        op(cpurf_pkg::OP_PULL_UPPER_INDEX, 16'h0);
        idle();
        chk(index_pair, 16'h1000);
        chk(stack_top_ptr, 16'h0080);
        op(cpurf_pkg::OP_LDA, 16'h0010);
        op(cpurf_pkg::OP_SUB, 16'h0020);
        chk(work_byte, 8'hf0);
        chk(flag_reg, 8'h75);
        chk(signed_lt, 1'b1);
        op(cpurf_pkg::OP_SEI, 16'h0);
        irq_pend <= 8'h01;
        repeat (4) @(posedge aclk);
        irq_pend <= 8'h00;
        chk(ack_seen, 8'h02);
        chk(flag_reg, 8'h7d);
        $display("test ops done");
    endtask : t_ops
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {irq_pend, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        seq_req = '0;
        t_reset();
        t_bus();
        t_alu();
        t_stack();
        t_irq();
        t_ret();
        t_ops();
        conclude();
    end
endmodule : testbench
`default_nettype wire
